// >>> toc_map.svh
// Constants of the timer output compare block: mode codes, reset values, counter limits.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef TOC_MAP_SVH
`define TOC_MAP_SVH
// =====================================================================
// Waveform select codes
`define TOC_WGM_NORMAL 3'h0
`define TOC_WGM_PC_FF 3'h1
`define TOC_WGM_CTC 3'h2
`define TOC_WGM_FAST_FF 3'h3
`define TOC_WGM_PC_OCRA 3'h5
`define TOC_WGM_FAST_OCRA 3'h7
// =====================================================================
// Counter limits and reset values
`define TOC_BOTTOM 8'h00
`define TOC_MAX 8'hFF
`define TOC_CNT_RST 8'h00
`define TOC_CMP_RST 8'h00
`define TOC_WAVE_RST 1'b0
// =====================================================================
// Compare output action codes
`define TOC_COM_NONE 2'h0
`define TOC_COM_TOGGLE 2'h1
`define TOC_COM_CLEAR 2'h2
`define TOC_COM_SET 2'h3
`endif

// >>> toc_pkg.sv
// Types shared by the timer output compare block.
// Assumes toc_map.svh supplies every numeric figure.
package toc_pkg;
   typedef logic [7:0] toc_byte_t;
   typedef logic [1:0] toc_com_t;
   typedef enum logic [1:0] {TOC_KIND_NORMAL, TOC_KIND_CTC, TOC_KIND_FAST, TOC_KIND_PC} toc_kind_e;
   typedef enum logic {TOC_DIR_UP, TOC_DIR_DOWN} toc_dir_e;
endpackage

// >>> toc_cmp_if.sv
// Interface carrying counter state from the counter core to each compare unit.
// Assumes one driver (the top) and compare units as readers.
`timescale 1ns/10ps
interface toc_cmp_if;
   logic tick;
   logic [7:0] count;
   logic block;
   logic at_top;
   logic at_bottom;
   logic is_pwm;
   logic is_fast;
   logic down;
   modport core (output tick, output count, output block, output at_top, output at_bottom,
                 output is_pwm, output is_fast, output down);
   modport unit (input tick, input count, input block, input at_top, input at_bottom,
                 input is_pwm, input is_fast, input down);
endinterface

// >>> toc_cmp_unit.sv
// One compare unit: compare value store, match flag, wave output bit.
// Assumes the shared counter state arrives over toc_cmp_if.
`timescale 1ns/10ps
`include "toc_map.svh"
module toc_cmp_unit (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   toc_cmp_if.unit cif,
   input wire logic [7:0] cmp_wdata_i,
   input wire logic cmp_we_i,
   input wire logic [1:0] action_i,
   input wire logic force_i,
   input wire logic flag_clr_i,
   output logic [7:0] cmp_rdata_o,
   output logic [7:0] cmp_active_o,
   output logic flag_o,
   output logic wave_o
);
   logic [7:0] act_ff, nxt_act;
   logic [7:0] buf_ff, nxt_buf;
   logic flag_ff, nxt_flag;
   logic wave_ff, nxt_wave;
   logic match;
   logic pwm_match_val;

   // =====================================================================
   // Match detect; a counter write blocks matches until the next tick.
   assign match = cif.tick && !cif.block && (cif.count == act_ff);

   // Fast PWM clears on match when non-inverted; phase correct depends on direction.
   always_comb begin
      pwm_match_val = 1'b0;
      if (cif.is_fast) begin
         pwm_match_val = action_i[0];
      end else begin
         pwm_match_val = action_i[0] ^ cif.down;
      end
   end

   // =====================================================================
   // Next state of the compare store, flag and wave bit.
   always_comb begin
      nxt_act = act_ff;
      nxt_buf = buf_ff;
      nxt_flag = flag_ff;
      nxt_wave = wave_ff;
      if (cif.is_pwm) begin
         if (cmp_we_i) begin
            nxt_buf = cmp_wdata_i;
         end
         if (cif.tick && ((cif.is_fast && cif.at_bottom) || (!cif.is_fast && cif.at_top))) begin
            nxt_act = buf_ff;
         end
      end else if (cmp_we_i) begin
         nxt_act = cmp_wdata_i;
         nxt_buf = cmp_wdata_i;
      end
      // Clear first so that a real match in the same cycle wins.
      if (flag_clr_i) begin
         nxt_flag = 1'b0;
      end
      if (match) begin
         nxt_flag = 1'b1;
      end
      // Action bits are read live, never buffered.
      if (!cif.is_pwm && (match || force_i)) begin
         case (action_i)
            `TOC_COM_TOGGLE: nxt_wave = !wave_ff;
            `TOC_COM_CLEAR: nxt_wave = 1'b0;
            `TOC_COM_SET: nxt_wave = 1'b1;
            default: nxt_wave = wave_ff;
         endcase
      end else if (cif.is_pwm && action_i[1]) begin
         if (match) begin
            nxt_wave = pwm_match_val;
         end else if (cif.tick && cif.is_fast && cif.at_top) begin
            nxt_wave = !action_i[0];
         end
      end else if (cif.is_pwm && (action_i == `TOC_COM_TOGGLE) && match) begin
         nxt_wave = !wave_ff;
      end
   end

   // Registers only; mode changes leave the wave bit untouched.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         act_ff <= `TOC_CMP_RST;
         buf_ff <= `TOC_CMP_RST;
         flag_ff <= 1'b0;
         wave_ff <= `TOC_WAVE_RST;
      end else begin
         act_ff <= nxt_act;
         buf_ff <= nxt_buf;
         flag_ff <= nxt_flag;
         wave_ff <= nxt_wave;
      end
   end

   assign cmp_rdata_o = cif.is_pwm ? buf_ff : act_ff;
   assign cmp_active_o = act_ff;
   assign flag_o = flag_ff;
   assign wave_o = wave_ff;
endmodule // toc_cmp_unit

// >>> toc_timer.sv
// Top of the 8-bit timer output compare block: counter core, two compare units, pin override.
// Assumes tick_i is a one-cycle enable from an outside clock-select divider; all inputs synchronous.
`timescale 1ns/10ps
`include "toc_map.svh"
module toc_timer (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic tick_i,
   input wire logic [2:0] waveform_select_i,
   input wire logic [7:0] count_value_wdata_i,
   input wire logic count_value_we_i,
   output logic [7:0] count_value_o,
   input wire logic [7:0] compare_value_reg_a_wdata_i,
   input wire logic compare_value_reg_a_we_i,
   output logic [7:0] compare_value_reg_a_o,
   input wire logic [7:0] compare_value_reg_b_wdata_i,
   input wire logic compare_value_reg_b_we_i,
   output logic [7:0] compare_value_reg_b_o,
   input wire logic [1:0] compare_output_action_a_i,
   input wire logic [1:0] compare_output_action_b_i,
   input wire logic force_compare_strobe_a_i,
   input wire logic force_compare_strobe_b_i,
   input wire logic compare_match_flag_a_clr_i,
   input wire logic compare_match_flag_b_clr_i,
   input wire logic overflow_flag_clr_i,
   output logic compare_match_flag_a_o,
   output logic compare_match_flag_b_o,
   output logic overflow_flag_o,
   output logic wave_output_a_o,
   output logic wave_output_b_o,
   input wire logic port_value_a_i,
   input wire logic port_value_b_i,
   input wire logic wave_pin_direction_a_i,
   input wire logic wave_pin_direction_b_i,
   output logic pin_a_o,
   output logic pin_a_oe_o,
   output logic pin_b_o,
   output logic pin_b_oe_o
);
   toc_cmp_if cif_a();
   toc_cmp_if cif_b();

   logic [7:0] cnt_ff, nxt_cnt;
   logic block_ff, nxt_block;
   logic dir_ff, nxt_dir;
   logic ovf_ff, nxt_ovf;
   logic [7:0] top_val;
   logic [7:0] ocra_active;
   toc_pkg::toc_kind_e kind;
   logic is_pwm;

   // =====================================================================
   // Mode decode, used by counter and both units.
   function automatic toc_pkg::toc_kind_e toc_kind_of(input logic [2:0] wgm);
      case (wgm)
         `TOC_WGM_NORMAL: toc_kind_of = toc_pkg::TOC_KIND_NORMAL;
         `TOC_WGM_CTC: toc_kind_of = toc_pkg::TOC_KIND_CTC;
         `TOC_WGM_FAST_FF, `TOC_WGM_FAST_OCRA: toc_kind_of = toc_pkg::TOC_KIND_FAST;
         `TOC_WGM_PC_FF, `TOC_WGM_PC_OCRA: toc_kind_of = toc_pkg::TOC_KIND_PC;
         default: toc_kind_of = toc_pkg::TOC_KIND_NORMAL;
      endcase
   endfunction

   // Waveform select and the active compare A value shape the count; action bits are never consulted here.
   assign kind = toc_kind_of(waveform_select_i);
   assign is_pwm = (kind == toc_pkg::TOC_KIND_FAST) || (kind == toc_pkg::TOC_KIND_PC);
   assign top_val = (waveform_select_i[2] || (kind == toc_pkg::TOC_KIND_CTC)) ? ocra_active : `TOC_MAX;

   // =====================================================================
   // Counter next state.
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_dir = dir_ff;
      nxt_ovf = ovf_ff && !overflow_flag_clr_i; // Software clear is taken first, so a set below always wins.
      nxt_block = block_ff;
      if (tick_i) begin
         nxt_block = 1'b0;
         case (kind)
            toc_pkg::TOC_KIND_NORMAL: begin
               nxt_cnt = cnt_ff + 8'h01;
               nxt_dir = toc_pkg::TOC_DIR_UP;
               if (cnt_ff == `TOC_MAX) begin
                  nxt_ovf = 1'b1;
               end
            end
            toc_pkg::TOC_KIND_CTC: begin
               nxt_dir = toc_pkg::TOC_DIR_UP;
               if (cnt_ff == top_val && !block_ff) begin
                  nxt_cnt = `TOC_BOTTOM;
               end else begin
                  nxt_cnt = cnt_ff + 8'h01;
               end
               if (cnt_ff == `TOC_MAX) begin
                  nxt_ovf = 1'b1;
               end
            end
            toc_pkg::TOC_KIND_FAST: begin
               nxt_dir = toc_pkg::TOC_DIR_UP;
               if (cnt_ff == top_val) begin
                  nxt_cnt = `TOC_BOTTOM;
                  nxt_ovf = 1'b1;
               end else begin
                  nxt_cnt = cnt_ff + 8'h01;
               end
            end
            toc_pkg::TOC_KIND_PC: begin
               if (dir_ff == toc_pkg::TOC_DIR_UP) begin
                  if (cnt_ff == top_val) begin
                     nxt_dir = toc_pkg::TOC_DIR_DOWN;
                     nxt_cnt = cnt_ff - 8'h01;
                  end else begin
                     nxt_cnt = cnt_ff + 8'h01;
                  end
               end else if (cnt_ff == `TOC_BOTTOM) begin
                  nxt_dir = toc_pkg::TOC_DIR_UP;
                  nxt_cnt = cnt_ff + 8'h01;
               end else begin
                  nxt_cnt = cnt_ff - 8'h01;
                  if (cnt_ff == 8'h01) begin
                     nxt_ovf = 1'b1;
                  end
               end
            end
            default: nxt_cnt = cnt_ff;
         endcase
      end
      // A write beats counting and arms the match block, held until the next tick, even with no tick.
      if (count_value_we_i) begin
         nxt_cnt = count_value_wdata_i;
         nxt_block = 1'b1;
      end
   end

   // Counter registers.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_ff <= `TOC_CNT_RST;
         dir_ff <= toc_pkg::TOC_DIR_UP;
         ovf_ff <= 1'b0;
         block_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         dir_ff <= nxt_dir;
         ovf_ff <= nxt_ovf;
         block_ff <= nxt_block;
      end
   end

   // =====================================================================
   // Shared counter state to both units.
   assign cif_a.tick = tick_i;
   assign cif_a.count = cnt_ff;
   assign cif_a.block = block_ff;
   assign cif_a.at_top = (cnt_ff == top_val);
   assign cif_a.at_bottom = (cnt_ff == `TOC_BOTTOM);
   assign cif_a.is_pwm = is_pwm;
   assign cif_a.is_fast = (kind == toc_pkg::TOC_KIND_FAST);
   assign cif_a.down = dir_ff;
   assign cif_b.tick = tick_i;
   assign cif_b.count = cnt_ff;
   assign cif_b.block = block_ff;
   assign cif_b.at_top = (cnt_ff == top_val);
   assign cif_b.at_bottom = (cnt_ff == `TOC_BOTTOM);
   assign cif_b.is_pwm = is_pwm;
   assign cif_b.is_fast = (kind == toc_pkg::TOC_KIND_FAST);
   assign cif_b.down = dir_ff;

   // Two independent units.
   toc_cmp_unit u_cmp_a (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .cif(cif_a),
      .cmp_wdata_i(compare_value_reg_a_wdata_i),
      .cmp_we_i(compare_value_reg_a_we_i),
      .action_i(compare_output_action_a_i),
      .force_i(force_compare_strobe_a_i),
      .flag_clr_i(compare_match_flag_a_clr_i),
      .cmp_rdata_o(compare_value_reg_a_o),
      .cmp_active_o(ocra_active),
      .flag_o(compare_match_flag_a_o),
      .wave_o(wave_output_a_o)
   );

   toc_cmp_unit u_cmp_b (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .cif(cif_b),
      .cmp_wdata_i(compare_value_reg_b_wdata_i),
      .cmp_we_i(compare_value_reg_b_we_i),
      .action_i(compare_output_action_b_i),
      .force_i(force_compare_strobe_b_i),
      .flag_clr_i(compare_match_flag_b_clr_i),
      .cmp_rdata_o(compare_value_reg_b_o),
      .cmp_active_o(),
      .flag_o(compare_match_flag_b_o),
      .wave_o(wave_output_b_o)
   );

   // =====================================================================
   // Pin override; direction always comes from the direction bit, so software can preset the wave first.
   assign pin_a_o = (compare_output_action_a_i != `TOC_COM_NONE) ? wave_output_a_o : port_value_a_i;
   assign pin_b_o = (compare_output_action_b_i != `TOC_COM_NONE) ? wave_output_b_o : port_value_b_i;
   assign pin_a_oe_o = wave_pin_direction_a_i;
   assign pin_b_oe_o = wave_pin_direction_b_i;
   assign count_value_o = cnt_ff;
   assign overflow_flag_o = ovf_ff;
endmodule // toc_timer

// >>> toc_timer_assertions.sv
// Checker for the timer output compare top: counter, flag, wave and pin timing.
// Assumes a bind onto toc_timer; it sees only that module's ports.
`timescale 1ns/10ps
`include "toc_map.svh"
module toc_timer_assertions (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic tick_i,
   input wire logic [2:0] waveform_select_i,
   input wire logic count_value_we_i,
   input wire logic [7:0] count_value_wdata_i,
   input wire logic [7:0] count_value_o,
   input wire logic [7:0] compare_value_reg_a_o,
   input wire logic [1:0] compare_output_action_a_i,
   input wire logic force_compare_strobe_a_i,
   input wire logic compare_match_flag_a_o,
   input wire logic overflow_flag_o,
   input wire logic wave_output_a_o,
   input wire logic port_value_a_i,
   input wire logic wave_pin_direction_a_i,
   input wire logic pin_a_o,
   input wire logic pin_a_oe_o
);
   // =====================================================================
   // Match block tracker
   logic blk_ff;
   logic nxt_blk;
   logic norm;
   // A counter write arms the block, and only a timer tick uses it up, so a stopped timer keeps it armed.
   always_comb begin
      nxt_blk = tick_i ? 1'b0 : blk_ff;
      if (count_value_we_i) begin
         nxt_blk = 1'b1;
      end
   end
   // Register the tracker.
   always_ff @(posedge clk_i) begin
      blk_ff <= sys_rst_i ? 1'b0 : nxt_blk;
   end
   // Normal mode with no counter write in the same cycle.
   assign norm = (waveform_select_i == `TOC_WGM_NORMAL) && !count_value_we_i;
   // =====================================================================
   // Properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_hit_a;
      norm && tick_i && (count_value_o == compare_value_reg_a_o);
   endsequence
   sequence s_force_a;
      norm && force_compare_strobe_a_i && !tick_i && !compare_match_flag_a_o;
   endsequence
   reset_clear_a: assert property (disable iff (1'b0) sys_rst_i |=>
      count_value_o == `TOC_CNT_RST && !wave_output_a_o && !compare_match_flag_a_o && !overflow_flag_o)
      else $error("reset left state set");
   count_up_a: assert property (norm && tick_i |=> count_value_o == 8'($past(count_value_o) + 8'h01))
      else $error("normal mode count step wrong");
   write_wins_a: assert property (count_value_we_i |=> count_value_o == $past(count_value_wdata_i))
      else $error("counter write lost");
   overflow_set_a: assert property (norm && tick_i && count_value_o == `TOC_MAX |=> overflow_flag_o)
      else $error("overflow flag not set at wrap");
   match_flag_a: assert property (s_hit_a ##0 !blk_ff |=> compare_match_flag_a_o)
      else $error("match flag not set");
   match_block_a: assert property (s_hit_a ##0 blk_ff && !compare_match_flag_a_o |=> !compare_match_flag_a_o)
      else $error("blocked match set flag");
   force_quiet_a: assert property (s_force_a |=> !compare_match_flag_a_o && $stable(count_value_o))
      else $error("force touched flag or counter");
   force_toggle_a: assert property (s_force_a ##0 compare_output_action_a_i == `TOC_COM_TOGGLE
      |=> wave_output_a_o != $past(wave_output_a_o))
      else $error("force toggle missed");
   pin_mux_a: assert property (pin_a_o == ((compare_output_action_a_i != `TOC_COM_NONE) ?
      wave_output_a_o : port_value_a_i))
      else $error("pin source wrong");
   pin_dir_a: assert property (pin_a_oe_o == wave_pin_direction_a_i)
      else $error("pin direction wrong");
endmodule // toc_timer_assertions

// >>> toc_timer_test.sv
// Self-checking bench for the timer output compare top: random counts plus hand-picked corners.
// Assumes the design, its map header and the checker are compiled ahead of this file.
`timescale 1ns/10ps
`include "toc_map.svh"
module toc_timer_test;
   localparam int WR_CNT = 0, WR_A = 1, FRC = 2, CLR = 3;
   logic clk_i, sys_rst_i, tick_i, count_value_we_i, compare_value_reg_a_we_i, compare_value_reg_b_we_i;
   logic force_compare_strobe_a_i, force_compare_strobe_b_i, overflow_flag_clr_i, port_value_a_i, port_value_b_i;
   logic compare_match_flag_a_clr_i, compare_match_flag_b_clr_i, wave_pin_direction_a_i, wave_pin_direction_b_i;
   logic [2:0] waveform_select_i;
   logic [1:0] compare_output_action_a_i, compare_output_action_b_i;
   logic [7:0] count_value_wdata_i, compare_value_reg_a_wdata_i, compare_value_reg_b_wdata_i;
   logic [7:0] count_value_o, compare_value_reg_a_o, compare_value_reg_b_o, v, c;
   logic compare_match_flag_a_o, compare_match_flag_b_o, overflow_flag_o, wave_output_a_o, wave_output_b_o;
   logic pin_a_o, pin_a_oe_o, pin_b_o, pin_b_oe_o, wm;
   int bad_count, checked, n;
   toc_timer dut (.*);
   // =====================================================================
   // Clock and watchdog
   // Free-running 100 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // The whole run needs at most about 1300 cycles; a hang is cut well after that.
   initial begin
      repeat (6000) @(posedge clk_i);
      bad_count++;
      report_and_stop();
   end
   // =====================================================================
   // Drivers and checks
   // Every driver acts on a rising edge and returns 1 ns after its last edge, so outputs have settled.
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tk(input int k);
      @(posedge clk_i);
      tick_i <= 1'b1;
      repeat (k) @(posedge clk_i);
      tick_i <= 1'b0;
      #1;
   endtask
   // One-cycle strobe: counter write, compare write on both units, force on both, or clear of all flags.
   // Unit B gets a value 128 away from unit A, so a shared store would show at once.
   task automatic pulse(input int which, input logic [7:0] d);
      @(posedge clk_i);
      count_value_wdata_i <= d;
      compare_value_reg_a_wdata_i <= d;
      compare_value_reg_b_wdata_i <= d ^ 8'h80;
      count_value_we_i <= (which == WR_CNT);
      compare_value_reg_a_we_i <= (which == WR_A);
      compare_value_reg_b_we_i <= (which == WR_A);
      {force_compare_strobe_a_i, force_compare_strobe_b_i} <= {2{which == FRC}};
      {compare_match_flag_a_clr_i, compare_match_flag_b_clr_i, overflow_flag_clr_i} <= {3{which == CLR}};
      @(posedge clk_i);
      {count_value_we_i, compare_value_reg_a_we_i, compare_value_reg_b_we_i} <= 3'h0;
      {force_compare_strobe_a_i, force_compare_strobe_b_i} <= 2'h0;
      {compare_match_flag_a_clr_i, compare_match_flag_b_clr_i, overflow_flag_clr_i} <= 3'h0;
      #1;
   endtask
   // Wave bit after a match or force under a given action.
   function automatic logic nxt_wave(input logic [1:0] act, input logic w);
      case (act)
         `TOC_COM_TOGGLE: nxt_wave = !w;
         `TOC_COM_CLEAR: nxt_wave = 1'b0;
         `TOC_COM_SET: nxt_wave = 1'b1;
         default: nxt_wave = w;
      endcase
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // =====================================================================
   // Main sequence
   // Reset, forced compares, pin override, counting, matches, blocking, then buffering.
   initial begin
      {tick_i, count_value_we_i, compare_value_reg_a_we_i, compare_value_reg_b_we_i, overflow_flag_clr_i} = '0;
      {force_compare_strobe_a_i, force_compare_strobe_b_i, compare_match_flag_a_clr_i, compare_match_flag_b_clr_i} = '0;
      {port_value_a_i, port_value_b_i, wave_pin_direction_a_i, wave_pin_direction_b_i, waveform_select_i} = '0;
      {compare_output_action_a_i, compare_output_action_b_i, count_value_wdata_i} = '0;
      {compare_value_reg_a_wdata_i, compare_value_reg_b_wdata_i} = '0;
      sys_rst_i = 1'b1;
      bad_count = 0;
      checked = 0;
      n = $urandom(32'h6f8c);
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk("count", count_value_o, `TOC_CNT_RST);
      chk("cmp a", compare_value_reg_a_o, `TOC_CMP_RST);
      chk("wave a", wave_output_a_o, `TOC_WAVE_RST);
      chk("flag a", compare_match_flag_a_o, 1'b0);
      $display("test reset done");
      wm = `TOC_WAVE_RST;
      for (int i = 0; i < 8; i++) begin
         compare_output_action_a_i <= i[1:0];
         pulse(FRC, 8'h00);
         wm = nxt_wave(i[1:0], wm);
         chk("force wave a", wave_output_a_o, wm);
         chk("force flag a", compare_match_flag_a_o, 1'b0);
         chk("force count", count_value_o, `TOC_CNT_RST);
         chk("force wave b", wave_output_b_o, 1'b0);
      end
      $display("test force done");
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_i);
         {port_value_a_i, port_value_b_i, wave_pin_direction_a_i, wave_pin_direction_b_i} <= 4'($urandom);
         {compare_output_action_a_i, compare_output_action_b_i} <= 4'($urandom);
         #1;
         chk("pin a", pin_a_o, (compare_output_action_a_i != `TOC_COM_NONE) ? wm : port_value_a_i);
         chk("pin a dir", pin_a_oe_o, wave_pin_direction_a_i);
         chk("pin b", pin_b_o, (compare_output_action_b_i != `TOC_COM_NONE) ? 1'b0 : port_value_b_i);
         chk("pin b dir", pin_b_oe_o, wave_pin_direction_b_i);
      end
      $display("test pin done");
      @(posedge clk_i);
      {compare_output_action_a_i, compare_output_action_b_i} <= 4'h0;
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? `TOC_MAX : 8'($urandom);
         n = (i == 0) ? 1 : 1 + $urandom % 300;
         pulse(CLR, 8'h00);
         pulse(WR_CNT, v);
         tk(n);
         chk("count", count_value_o, 8'(v + n));
         chk("overflow", overflow_flag_o, (v + n) > 255);
         chk("idle wave a", wave_output_a_o, wm);
      end
      $display("test count done");
      c = 8'($urandom);
      compare_output_action_a_i <= `TOC_COM_TOGGLE;
      pulse(WR_A, c);
      pulse(WR_CNT, c - 8'h03); // Counter is only written while stopped (tick low), in an up-counting mode.
      pulse(CLR, 8'h00);
      tk(3);
      chk("flag a early", compare_match_flag_a_o, 1'b0);
      tk(1);
      wm = !wm;
      chk("flag a", compare_match_flag_a_o, 1'b1);
      chk("match wave a", wave_output_a_o, wm);
      chk("cmp b", compare_value_reg_b_o, c ^ 8'h80);
      chk("flag b", compare_match_flag_b_o, 1'b0);
      pulse(CLR, 8'h00);
      pulse(WR_CNT, c);
      repeat (5) @(posedge clk_i);
      tk(1);
      chk("blocked flag a", compare_match_flag_a_o, 1'b0);
      chk("blocked wave a", wave_output_a_o, wm);
      chk("count", count_value_o, c + 8'h01);
      $display("test match done");
      pulse(WR_A, 8'hF0);
      chk("direct a", compare_value_reg_a_o, 8'hF0);
      waveform_select_i <= `TOC_WGM_FAST_FF;
      compare_output_action_a_i <= `TOC_COM_NONE;
      pulse(WR_A, 8'h40);
      chk("buffer a", compare_value_reg_a_o, 8'h40);
      chk("mode keep a", wave_output_a_o, wm);
      pulse(WR_CNT, 8'h30);
      pulse(CLR, 8'h00);
      tk(20);
      chk("old active a", compare_match_flag_a_o, 1'b0);
      tk(188);
      chk("count", count_value_o, 8'h00);
      tk(1);
      compare_output_action_a_i <= `TOC_COM_SET;
      pulse(CLR, 8'h00);
      tk(64);
      chk("new active a", compare_match_flag_a_o, 1'b1);
      chk("pwm wave a", wave_output_a_o, 1'b1);
      waveform_select_i <= `TOC_WGM_NORMAL;
      pulse(CLR, 8'h00);
      chk("active a", compare_value_reg_a_o, 8'h40);
      // Clear-on-match: the write lands in the active store, so the count clears at 5 at once.
      waveform_select_i <= `TOC_WGM_CTC;
      pulse(WR_A, 8'h05);
      chk("direct ctc a", compare_value_reg_a_o, 8'h05);
      pulse(WR_CNT, 8'h00);
      tk(7);
      chk("ctc count", count_value_o, 8'h01);
      $display("test buffer done");
      report_and_stop();
   end
endmodule // toc_timer_test
bind toc_timer toc_timer_assertions chk (.*);
